// ==== hw/ltd_defs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  level threshold detector.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef LTD_DEFS_SVH
`define LTD_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LTD_OFS_CTRL      12'h000
`define LTD_OFS_LEVEL     12'h004
`define LTD_OFS_DELAY     12'h008
`define LTD_OFS_STATUS    12'h00C
`define LTD_OFS_IRQ_STAT  12'h010
`define LTD_OFS_IRQ_MASK  12'h014
`define LTD_OFS_CEILING   12'h018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LTD_CTRL_SRC_LSB   0
`define LTD_CTRL_SRC_MSB   2
`define LTD_CTRL_ROUTE_BIT 4
`define LTD_IRQ_ON_BIT     0
`define LTD_IRQ_OFF_BIT    1

// ----------------------------------------------------------------------
// Reset values (level in tenths of percent, delay in tenths of second)
// ----------------------------------------------------------------------
`define LTD_RST_SRC       3'h2
`define LTD_RST_ROUTE     1'h0
`define LTD_RST_LEVEL     16'h0064
`define LTD_RST_DELAY     12'h0064
`define LTD_RST_CEILING   16'h03E8
`define LTD_LEVEL_MIN     16'h0001
`define LTD_PCT_MAX       16'h03E8
`define LTD_DELAY_MAX     12'h0BB8

// ----------------------------------------------------------------------
// Timing: tenth-second step at 200 MHz
// ----------------------------------------------------------------------
`define LTD_STEP_MS       100
`define LTD_CLK_MHZ       200
`define LTD_STEP_CYC      (`LTD_STEP_MS * 1000 * `LTD_CLK_MHZ)

`endif

// ==== hw/ltd_pkg.sv ====
/*
  Types shared by the level threshold detector files.
  Assumes ltd_defs.svh holds the numeric constants.
*/
package ltd_pkg;

  // Detector input sources
  typedef enum logic [2:0] {
    SRC_CURRENT_LOOP_FEEDBACK = 3'h0,
    SRC_SPEED_LOOP_FEEDBACK = 3'h1,
    SRC_RAMP_INPUT_PROBE = 3'h2,
    SRC_RAMP_RESULT = 3'h3,
    SRC_CHOSEN_SPEED_SOURCE = 3'h4
  } ltd_src_t;

  // Regulator signal bundle, signed, full scale = 1000 tenths
  typedef struct packed {
    logic signed [15:0] current_loop_feedback;
    logic signed [15:0] speed_loop_feedback;
    logic signed [15:0] ramp_input_probe;
    logic signed [15:0] ramp_result;
    logic signed [15:0] chosen_speed_source;
  } ltd_sig_t;

  // Detector configuration
  typedef struct packed {
    logic [15:0] level;
    logic [11:0] delay;
  } ltd_cfg_t;

endpackage

// ==== hw/ltd_qual.sv ====
/*
  Qualification core: magnitude compare and delay timer.
  Assumes the input magnitude and configuration are synchronous to core_clk.
*/
`timescale 1ns/10ps
`include "ltd_defs.svh"

module ltd_qual #(
  parameter int unsigned STEP_CYC = `LTD_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [15:0] mag,
  input wire ltd_pkg::ltd_cfg_t cfg,
  output logic det_on
);

  logic [31:0] sub_q, sub_d;
  logic [11:0] step_q, step_d;
  logic on_q, on_d;
  logic above;

  // ----------------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------------
  assign above = (mag >= cfg.level);

  // Output only after strictly longer than the delay
  always_comb begin
    sub_d = sub_q;
    step_d = step_q;
    on_d = on_q;
    if (!above) begin
      sub_d = 32'h0000_0000;
      step_d = 12'h000;
      on_d = 1'b0;
    end else if (!on_q) begin
      if (step_q >= cfg.delay) begin
        on_d = 1'b1;
      end else if (sub_q >= STEP_CYC - 1) begin
        sub_d = 32'h0000_0000;
        step_d = step_q + 12'h001;
      end else begin
        sub_d = sub_q + 32'h0000_0001;
      end
    end
  end

  // Reset clears the timer and holds output off
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sub_q <= 32'h0000_0000;
      step_q <= 12'h000;
      on_q <= 1'b0;
    end else begin
      sub_q <= sub_d;
      step_q <= step_d;
      on_q <= on_d;
    end
  end

  assign det_on = on_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_drop_clears;
    @(posedge core_clk) disable iff (!arst_n)
      !above |=> !on_q && step_q == 12'h000;
  endproperty
  a_drop_clears: assert property (p_drop_clears)
    else $error("output not cleared after drop");

  property p_rise_needs_above;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(on_q) |-> $past(above && step_q >= cfg.delay);
  endproperty
  a_rise_needs_above: assert property (p_rise_needs_above)
    else $error("output rose without qualification");

  property p_timer_idle_below;
    @(posedge core_clk) disable iff (!arst_n)
      !above |=> sub_q == 32'h0000_0000;
  endproperty
  a_timer_idle_below: assert property (p_timer_idle_below)
    else $error("timer ran while below level");

  c_on: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(on_q));
  c_drop: cover property (@(posedge core_clk) disable iff (!arst_n)
    $fell(on_q));

endmodule

// ==== hw/ltd_top.sv ====
/*
  Level threshold detector with APB register file and interrupt.
  Assumes regulator signals are synchronous to core_clk; the qualification
  step count may be shortened by parameter for simulation.
*/
`timescale 1ns/10ps
`include "ltd_defs.svh"

// Contract
// - Output turns on only after the input stays at or above the level longer than the delay.
// - The magnitude of the input is compared and the timer starts once it reaches the level.
// - A magnitude below the level clears the timer and turns the output off at once.
// - Expansion output two follows the detector only when its route selects it.
// - Source is one of five regulator signals, ramp input probe by default.
// - Level is 0.1 to 100.0 percent, default 10.0 percent, for speed sources; clamped only on a level write, not on a source change.
// - With current feedback the level range runs from 0.1 to the current ceiling; clamped only on a level write, not on a ceiling or source change.
// - Delay is 0 to 300.0 s in tenth steps, default 10.0 s.
module ltd_top #(
  parameter int unsigned STEP_CYC = `LTD_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ltd_pkg::ltd_sig_t sig,
  output logic level_detect_out,
  output logic aux_output_two,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  ltd_pkg::ltd_src_t src_q, src_d;
  logic route_q, route_d;
  logic [15:0] level_q, level_d;
  logic [11:0] delay_q, delay_d;
  logic [15:0] ceil_q, ceil_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imask_q, imask_d;
  logic [31:0] rdata_q, rdata_d;
  logic aux_q, aux_d;
  logic det_on, det_prev_q;
  logic [1:0] ev;
  logic wr, rd, hit;
  logic signed [15:0] raw;
  logic [15:0] mag;
  logic [15:0] lvl_max;
  logic [15:0] wlevel;
  logic [11:0] wdelay;
  ltd_pkg::ltd_cfg_t cfg;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  // Reads decode in the setup cycle so read data is a flop by access
  assign rd = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      `LTD_OFS_CTRL, `LTD_OFS_LEVEL, `LTD_OFS_DELAY, `LTD_OFS_STATUS,
      `LTD_OFS_IRQ_STAT, `LTD_OFS_IRQ_MASK, `LTD_OFS_CEILING: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------------
  // Source select and magnitude
  // ----------------------------------------------------------------------
  always_comb begin
    case (src_q)
      ltd_pkg::SRC_CURRENT_LOOP_FEEDBACK: raw = sig.current_loop_feedback;
      ltd_pkg::SRC_SPEED_LOOP_FEEDBACK: raw = sig.speed_loop_feedback;
      ltd_pkg::SRC_RAMP_INPUT_PROBE: raw = sig.ramp_input_probe;
      ltd_pkg::SRC_RAMP_RESULT: raw = sig.ramp_result;
      ltd_pkg::SRC_CHOSEN_SPEED_SOURCE: raw = sig.chosen_speed_source;
      default: raw = 16'sh0000;
    endcase
  end
  // Saturate the most negative code so the magnitude never wraps
  assign mag = raw[15] ? ((raw == 16'sh8000) ? 16'h7FFF :
                          16'(-raw)) : 16'(raw);

  // Level ceiling depends on source kind
  assign lvl_max = (src_q == ltd_pkg::SRC_CURRENT_LOOP_FEEDBACK) ?
                   ceil_q : `LTD_PCT_MAX;

  // Write values clamped into their legal ranges
  always_comb begin
    wlevel = pwdata[15:0];
    if (wlevel < `LTD_LEVEL_MIN) begin
      wlevel = `LTD_LEVEL_MIN;
    end else if (wlevel > lvl_max) begin
      wlevel = lvl_max;
    end
    wdelay = pwdata[11:0];
    if (wdelay > `LTD_DELAY_MAX) begin
      wdelay = `LTD_DELAY_MAX;
    end
  end

  // ----------------------------------------------------------------------
  // Detector core
  // ----------------------------------------------------------------------
  assign cfg.level = level_q;
  assign cfg.delay = delay_q;

  ltd_qual #(
    .STEP_CYC(STEP_CYC)
  ) u_qual (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .mag(mag),
    .cfg(cfg),
    .det_on(det_on)
  );

  // Detector events: turn-on and turn-off edges
  assign ev[`LTD_IRQ_ON_BIT] = det_on && !det_prev_q;
  assign ev[`LTD_IRQ_OFF_BIT] = !det_on && det_prev_q;

  // ----------------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------------
  always_comb begin
    src_d = src_q;
    route_d = route_q;
    level_d = level_q;
    delay_d = delay_q;
    ceil_d = ceil_q;
    imask_d = imask_q;
    ist_d = ist_q;
    rdata_d = rdata_q;
    if (wr) begin
      case (paddr)
        `LTD_OFS_CTRL: begin
          // Unlisted source codes are ignored, keeping a valid source
          if (pwdata[`LTD_CTRL_SRC_MSB:`LTD_CTRL_SRC_LSB] <= 3'h4) begin
            src_d = ltd_pkg::ltd_src_t'(
              pwdata[`LTD_CTRL_SRC_MSB:`LTD_CTRL_SRC_LSB]);
          end
          route_d = pwdata[`LTD_CTRL_ROUTE_BIT];
        end
        `LTD_OFS_LEVEL: level_d = wlevel;
        `LTD_OFS_DELAY: delay_d = wdelay;
        `LTD_OFS_CEILING: ceil_d = (pwdata[15:0] < `LTD_LEVEL_MIN) ?
                                   `LTD_LEVEL_MIN : pwdata[15:0];
        `LTD_OFS_IRQ_STAT: ist_d = ist_q & ~pwdata[1:0];
        `LTD_OFS_IRQ_MASK: imask_d = pwdata[1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    ist_d = ist_d | ev;
    if (rd) begin
      case (paddr)
        `LTD_OFS_CTRL: rdata_d = {27'h000_0000, route_q, 1'b0, src_q};
        `LTD_OFS_LEVEL: rdata_d = {16'h0000, level_q};
        `LTD_OFS_DELAY: rdata_d = {20'h0_0000, delay_q};
        `LTD_OFS_STATUS: rdata_d = {30'h0000_0000, aux_q, det_on};
        `LTD_OFS_IRQ_STAT: rdata_d = {30'h0000_0000, ist_q};
        `LTD_OFS_IRQ_MASK: rdata_d = {30'h0000_0000, imask_q};
        `LTD_OFS_CEILING: rdata_d = {16'h0000, ceil_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Routing of expansion output two
    aux_d = route_q && det_on;
  end

  // Registers; output route gating is registered for a clean pin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_d_reset: begin
        src_q <= ltd_pkg::ltd_src_t'(`LTD_RST_SRC);
      end
      route_q <= `LTD_RST_ROUTE;
      level_q <= `LTD_RST_LEVEL;
      delay_q <= `LTD_RST_DELAY;
      ceil_q <= `LTD_RST_CEILING;
      imask_q <= 2'h0;
      ist_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      aux_q <= 1'b0;
      det_prev_q <= 1'b0;
    end else begin
      src_q <= src_d;
      route_q <= route_d;
      level_q <= level_d;
      delay_q <= delay_d;
      ceil_q <= ceil_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      rdata_q <= rdata_d;
      aux_q <= aux_d;
      det_prev_q <= det_on;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Read data comes from the flop loaded in the setup cycle; it stands
  // through the whole zero-wait access phase
  assign prdata = rdata_q;
  assign level_detect_out = det_on;
  assign aux_output_two = aux_q;
  assign irq = |(ist_q & imask_q);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_route_gate;
    @(posedge core_clk) disable iff (!arst_n)
      aux_output_two |-> $past(route_q) && $past(det_on);
  endproperty
  a_route_gate: assert property (p_route_gate)
    else $error("output two driven without route");

  property p_route_follow;
    @(posedge core_clk) disable iff (!arst_n)
      route_q && det_on |=> aux_output_two;
  endproperty
  a_route_follow: assert property (p_route_follow)
    else $error("output two not following detector");

  property p_level_range;
    @(posedge core_clk) disable iff (!arst_n)
      wr && paddr == `LTD_OFS_LEVEL |=> level_q >= `LTD_LEVEL_MIN &&
        level_q <= $past(lvl_max);
  endproperty
  a_level_range: assert property (p_level_range)
    else $error("level outside range");

  property p_delay_range;
    @(posedge core_clk) disable iff (!arst_n)
      delay_q <= `LTD_DELAY_MAX;
  endproperty
  a_delay_range: assert property (p_delay_range)
    else $error("delay above maximum");

  property p_src_valid;
    @(posedge core_clk) disable iff (!arst_n)
      src_q <= ltd_pkg::SRC_CHOSEN_SPEED_SOURCE;
  endproperty
  a_src_valid: assert property (p_src_valid)
    else $error("invalid source");

  property p_off_below;
    @(posedge core_clk) disable iff (!arst_n)
      mag < level_q && !(wr && paddr == `LTD_OFS_LEVEL) &&
      !(wr && paddr == `LTD_OFS_CTRL) |=> !level_detect_out;
  endproperty
  a_off_below: assert property (p_off_below)
    else $error("output on while below level");

  property p_src_refused;
    @(posedge core_clk) disable iff (!arst_n)
      wr && paddr == `LTD_OFS_CTRL &&
        pwdata[`LTD_CTRL_SRC_MSB:`LTD_CTRL_SRC_LSB] > 3'h4
        |=> $stable(src_q);
  endproperty
  a_src_refused: assert property (p_src_refused)
    else $error("refused source code was taken");

  property p_delay_write;
    @(posedge core_clk) disable iff (!arst_n)
      wr && paddr == `LTD_OFS_DELAY && pwdata[11:0] <= `LTD_DELAY_MAX
        |=> delay_q == $past(pwdata[11:0]);
  endproperty
  a_delay_write: assert property (p_delay_write)
    else $error("legal delay not stored");

  // Unrouted output two stays low whatever the detector does
  property p_aux_unrouted;
    @(posedge core_clk) disable iff (!arst_n)
      !route_q |=> !aux_output_two;
  endproperty
  a_aux_unrouted: assert property (p_aux_unrouted)
    else $error("output two driven while unrouted");

  // Interrupt status: a turn-on event latches, a one written clears
  property p_on_event_sets;
    @(posedge core_clk) disable iff (!arst_n)
      ev[`LTD_IRQ_ON_BIT] |=> ist_q[`LTD_IRQ_ON_BIT];
  endproperty
  a_on_event_sets: assert property (p_on_event_sets)
    else $error("turn-on event not latched");

  property p_on_clear;
    @(posedge core_clk) disable iff (!arst_n)
      wr && paddr == `LTD_OFS_IRQ_STAT && pwdata[`LTD_IRQ_ON_BIT] &&
        !ev[`LTD_IRQ_ON_BIT] |=> !ist_q[`LTD_IRQ_ON_BIT];
  endproperty
  a_on_clear: assert property (p_on_clear)
    else $error("turn-on status not cleared");

  c_route_on: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(aux_output_two));
  c_irq: cover property (@(posedge core_clk) disable iff (!arst_n)
    $rose(irq));
  c_current: cover property (@(posedge core_clk) disable iff (!arst_n)
    src_q == ltd_pkg::SRC_CURRENT_LOOP_FEEDBACK && det_on);

endmodule

// ==== tb/ltd_drive_model.sv ====
/*
  Stand-in for the drive regulators that feed the detector.
  Assumes the bench picks which regulator carries the test value.
*/
`timescale 1ns/10ps

module ltd_drive_model (
  input wire logic [2:0] sel,
  input wire logic signed [15:0] val,
  output ltd_pkg::ltd_sig_t sig
);
  // Only the picked regulator carries the value; the rest sit at zero,
  // so a wrong source choice shows as a missing or spurious trip
  always_comb begin
    sig = '0;
    case (sel)
      3'h0: sig.current_loop_feedback = val;
      3'h1: sig.speed_loop_feedback = val;
      3'h2: sig.ramp_input_probe = val;
      3'h3: sig.ramp_result = val;
      default: sig.chosen_speed_source = val;
    endcase
  end
endmodule

// ==== tb/level_threshold_detector_tb.sv ====
/*
  Self-checking bench for the level threshold detector.
  Assumes ltd_top with a short step count and the drive model beside it.
*/
`timescale 1ns/10ps
`include "ltd_defs.svh"

module level_threshold_detector_tb;
  localparam int unsigned STEP = 4;
  logic core_clk, arst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, level_detect_out, aux_output_two, irq, er;
  logic [2:0] drv_sel;
  logic signed [15:0] drv_val;
  ltd_pkg::ltd_sig_t sig;
  int bad_count, n_tests, n;

  ltd_top #(.STEP_CYC(STEP)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sig(sig),
    .level_detect_out(level_detect_out), .aux_output_two(aux_output_two),
    .irq(irq)
  );
  ltd_drive_model drv_u (.sel(drv_sel), .val(drv_val), .sig(sig));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Compare, bus and timing tasks
  // ------------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One APB transfer opened on a fresh edge; waits for pready as long as
  // it takes (only the watchdog ends a hang), then leaves an idle edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd_chk(input string what, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, e, rd);
  endtask

  // Edges until the detector turns on, capped so a dead output ends
  task trip_time(output int c);
    c = 0;
    while (level_detect_out !== 1'b1 && c < 60) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    // End on an edge so the caller may drive inputs at once
    @(posedge core_clk);
  endtask

  task give_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    drv_sel = 3'h2;
    drv_val = 16'sd0;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge core_clk);
    chk1("det in reset", 1'b0, level_detect_out);
    arst_n <= 1'b1;
    rd_chk("ctrl", `LTD_OFS_CTRL, 32'h0000_0002);
    rd_chk("level", `LTD_OFS_LEVEL, 32'h0000_0064);
    rd_chk("delay", `LTD_OFS_DELAY, 32'h0000_0064);
    rd_chk("ceiling", `LTD_OFS_CEILING, 32'h0000_03E8);
    rd_chk("mask", `LTD_OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk("unmapped", 12'h01C, 32'h0000_0000);
    chk1("slverr", 1'b1, er);
    // Range limits: delay top, speed level top and bottom, current level above the speed top
    wr(`LTD_OFS_DELAY, 32'h0000_0FA0);
    rd_chk("delay max", `LTD_OFS_DELAY, 32'h0000_0BB8);
    wr(`LTD_OFS_CTRL, 32'h0000_0001);
    wr(`LTD_OFS_LEVEL, 32'h0000_05DC);
    rd_chk("level max", `LTD_OFS_LEVEL, 32'h0000_03E8);
    wr(`LTD_OFS_LEVEL, 32'h0000_0000);
    rd_chk("level min", `LTD_OFS_LEVEL, 32'h0000_0001);
    wr(`LTD_OFS_CTRL, 32'h0000_0000);
    wr(`LTD_OFS_CEILING, 32'h0000_07D0);
    wr(`LTD_OFS_LEVEL, 32'h0000_05DC);
    rd_chk("level cur", `LTD_OFS_LEVEL, 32'h0000_05DC);
    // Equal magnitude from below zero, two-step delay, route off
    wr(`LTD_OFS_CTRL, 32'h0000_0002);
    wr(`LTD_OFS_LEVEL, 32'h0000_0064);
    wr(`LTD_OFS_DELAY, 32'h0000_0002);
    wr(`LTD_OFS_IRQ_MASK, 32'h0000_0001);
    drv_val <= -16'sd100;
    trip_time(n);
    chk1("trip window", 1'b1, n >= 9 && n <= 15);
    @(posedge core_clk);
    #1;
    chk1("aux unrouted", 1'b0, aux_output_two);
    chk1("irq on", 1'b1, irq);
    wr(`LTD_OFS_IRQ_STAT, 32'h0000_0001);
    chk1("irq cleared", 1'b0, irq);
    // One count under the level drops the output at the next edge
    drv_val <= 16'sd99;
    @(posedge core_clk);
    #1;
    chk1("det off", 1'b0, level_detect_out);
    @(posedge core_clk);
    #1;
    chk1("irq masked", 1'b0, irq);
    rd_chk("irq stat", `LTD_OFS_IRQ_STAT, 32'h0000_0002);
    // A one-edge dip mid-count must restart the whole delay
    drv_val <= 16'sd100;
    repeat (6) @(posedge core_clk);
    drv_val <= 16'sd99;
    @(posedge core_clk);
    drv_val <= 16'sd100;
    trip_time(n);
    chk1("restart window", 1'b1, n >= 9 && n <= 15);
    // Route to output two
    drv_val <= 16'sd0;
    wr(`LTD_OFS_CTRL, 32'h0000_0012);
    wr(`LTD_OFS_DELAY, 32'h0000_0000);
    drv_val <= 16'sd200;
    trip_time(n);
    chk1("zero delay", 1'b1, n <= 7);
    @(posedge core_clk);
    #1;
    chk1("aux routed", 1'b1, aux_output_two);
    rd_chk("status", `LTD_OFS_STATUS, 32'h0000_0003);
    // Every source: a neighbour must not trip it, its own signal must
    for (int s = 0; s < 5; s++) begin
      drv_val <= 16'sd0;
      wr(`LTD_OFS_CTRL, 32'(s));
      wr(`LTD_OFS_LEVEL, 32'h0000_0064);
      drv_sel <= 3'((s + 1) % 5);
      drv_val <= 16'sd500;
      repeat (10) @(posedge core_clk);
      #1;
      chk1("other source", 1'b0, level_detect_out);
      @(posedge core_clk);
      drv_sel <= 3'(s);
      trip_time(n);
      chk1("own source", 1'b1, n <= 7);
    end
    // A source code past the last one is refused; route is still written
    wr(`LTD_OFS_CTRL, 32'h0000_0007);
    rd_chk("ctrl refused", `LTD_OFS_CTRL, 32'h0000_0004);
    // Reset while on; the default source carries the level, so the output
    // stays off until the default delay of 100 steps has run
    drv_sel <= 3'h2;
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk1("det reset", 1'b0, level_detect_out);
    chk1("aux reset", 1'b0, aux_output_two);
    chk1("irq reset", 1'b0, irq);
    @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (50) @(posedge core_clk);
    #1;
    chk1("requalify", 1'b0, level_detect_out);
    repeat (360) @(posedge core_clk);
    #1;
    chk1("requalified", 1'b1, level_detect_out);
    give_verdict();
  end
endmodule
